//--- design/hsc_addr_decode.sv
// tri-level address pin decoder
`timescale 1ns/1ps
module hsc_addr_decode
    import hsc_pkg::*;
(
    input wire logic [2:0] addr_sel_above_low,
    input wire logic [2:0] addr_sel_above_high,
    output logic [4:0] addr_code
);
    // one pin: below lower threshold is ground, above upper is tied high, between is open
    function automatic logic [1:0] hsc_trit(input logic above_low, input logic above_high);
        logic [1:0] t;
        t = HSC_TRIT_OPEN;
        if (!above_low) begin
            t = HSC_TRIT_GND;
        end else if (above_high) begin
            t = HSC_TRIT_INTERNAL_SUPPLY_PIN;
        end
        return t;
    endfunction : hsc_trit

    logic [1:0] digit [3];

    // each pin decoded on its own
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            assign digit[gi] = hsc_trit(addr_sel_above_low[gi], addr_sel_above_high[gi]);
        end
    endgenerate

    // pin 0 is the lowest digit, pin 2 the highest, giving 27 codes
    always_comb begin
        addr_code = {3'h0, digit[0]} + 5'(HSC_WEIGHT_1 * {3'h0, digit[1]})
                  + 5'(HSC_WEIGHT_2 * {3'h0, digit[2]});
    end
endmodule : hsc_addr_decode

//--- design/hsc_top.sv
// channel gating, interlock, status and alert logic of the hot-swap controller
`timescale 1ns/1ps
//
// Summary of operation
// - alert_n goes low when any channel's power good drops or any channel fault rises.
// - alert_n is open drain and pulls low as soon as any of the eight status bits is set.
// - a host read of the status register releases alert_n to high impedance, unless a channel event lands in the same cycle.
// - the status register holds one fault and one power-good bit for each of the four channels.
// - a low oring_enable bit holds that payload channel's block_gate_drive low.
// - whenever pass_gate_drive is commanded off, block_gate_drive is forced low too.
// - a low mgmt_channel_enable turns the management channel off by grounding its gate.
// - a floating mgmt_channel_enable counts as enabled.
// - three address pins choose one of 27 serial slave addresses.
// - each address pin is decoded as ground, tied to the internal supply, or open.
// - address pin 0 is the lowest digit, pin 1 the next, pin 2 the highest.
// - with interlock_disable low, a slot's payload stays off until its management output exceeds 2.85 V.
// - the status register is read only and any set bit drives the alert.
// - clearing payload_enable drives both pass and block gate drives to zero.
module hsc_top
    import hsc_pkg::*;
#(
    parameter logic [6:0] ADDR_BASE = HSC_ADDR_BASE_DFLT
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [1:0] payload_enable,
    input wire logic [1:0] oring_enable,
    input wire logic interlock_disable,
    input wire logic [1:0] mgmt_channel_enable,
    input wire logic [1:0] mgmt_channel_enable_open,
    input wire logic [1:0] mgmt_output_voltage_ok,
    input wire logic [3:0] channel_fault,
    input wire logic [3:0] power_good,
    input wire logic status_read,
    input wire logic [2:0] addr_sel_above_low,
    input wire logic [2:0] addr_sel_above_high,
    output logic [1:0] pass_gate_drive,
    output logic [1:0] block_gate_drive,
    output logic [1:0] mgmt_gate_drive,
    output logic [7:0] status,
    output logic alert_n_out,
    output logic alert_n_oe_n,
    output logic [6:0] slave_addr
);

    ////////////////////////////////////////////////////////////////////////////////
    // gate drive control

    logic [1:0] next_pass_gate_drive;
    logic [1:0] next_block_gate_drive;
    logic [1:0] next_mgmt_gate_drive;

    // per-slot gating; management channels are indexed by slot, same as payload
    genvar gs;
    generate
        for (gs = 0; gs < 2; gs++) begin : g_slot
            always_comb begin
                // payload waits for the management rail unless the interlock is disabled
                next_pass_gate_drive[gs] = payload_enable[gs]
                    & (interlock_disable | mgmt_output_voltage_ok[gs]);
                // block fet only follows the pass fet, never leads it
                next_block_gate_drive[gs] = next_pass_gate_drive[gs] & oring_enable[gs];
                // an open enable pin is pulled up inside, so it enables
                next_mgmt_gate_drive[gs] = mgmt_channel_enable[gs] | mgmt_channel_enable_open[gs];
            end
        end
    endgenerate

    // registered drives keep the gate pins glitch free when several inputs change at once
    // gate registers; all drives off in reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pass_gate_drive <= HSC_GATE_RST;
            block_gate_drive <= HSC_GATE_RST;
            mgmt_gate_drive <= HSC_GATE_RST;
        end else begin
            pass_gate_drive <= next_pass_gate_drive;
            block_gate_drive <= next_block_gate_drive;
            mgmt_gate_drive <= next_mgmt_gate_drive;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status register and alert

    logic [3:0] fault_q;
    logic [3:0] pg_q;
    logic [3:0] next_fault_q;
    logic [3:0] next_pg_q;
    logic [7:0] status_set;
    logic [7:0] next_status;
    logic next_alert_n_oe_n;

    // edges rather than levels, so a read is not undone at once by a fault that is still present
    // edge detection on the analog indicators, two status bits per channel
    genvar gc;
    generate
        for (gc = 0; gc < 4; gc++) begin : g_ch
            always_comb begin
                status_set[2 * gc + HSC_FAULT_POS] = channel_fault[gc] & ~fault_q[gc];
                status_set[2 * gc + HSC_PG_POS] = ~power_good[gc] & pg_q[gc];
            end
        end
    endgenerate

    // the read clears, but a fresh event in the same cycle wins so it is not lost
    always_comb begin
        next_fault_q = channel_fault;
        next_pg_q = power_good;
        next_status = (status & ~{HSC_STATUS_W{status_read}}) | status_set;
        next_alert_n_oe_n = ~(|next_status);
    end

    // a channel that stays faulted alerts once per fault edge, not for as long as it stays faulted
    // status and alert registers; pg history starts low so power-up is not an event
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fault_q <= 4'h0;
            pg_q <= 4'h0;
            status <= HSC_STATUS_RST;
            alert_n_oe_n <= 1'b1;
            alert_n_out <= 1'b0;
        end else begin
            fault_q <= next_fault_q;
            pg_q <= next_pg_q;
            status <= next_status;
            alert_n_oe_n <= next_alert_n_oe_n;
            alert_n_out <= 1'b0; // open drain: only ever drives low
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // slave address

    logic [4:0] addr_code;
    logic [6:0] next_slave_addr;

    hsc_addr_decode u_addr_decode (
        .addr_sel_above_low(addr_sel_above_low),
        .addr_sel_above_high(addr_sel_above_high),
        .addr_code(addr_code)
    );

    // no debounce: a strap moved at run time shows up in the address after one edge
    // pins are re-decoded every cycle; straps are expected to stay put
    always_comb begin
        next_slave_addr = ADDR_BASE + {2'h0, addr_code};
    end

    // address register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            slave_addr <= ADDR_BASE;
        end else begin
            slave_addr <= next_slave_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    AST_FAULT_RAISES_ALERT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (|(channel_fault & ~fault_q)) |=> (alert_n_oe_n == 1'b0))
        else $error("fault rise did not pull the alert low");

    AST_PG_DROP_RAISES_ALERT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (|(~power_good & pg_q)) |=> (alert_n_oe_n == 1'b0 && status != 8'h00))
        else $error("power good drop did not pull the alert low");

    AST_ALERT_MATCHES_STATUS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (alert_n_oe_n == 1'b0) == (status != 8'h00) && alert_n_out == 1'b0)
        else $error("alert does not follow the status register");

    AST_READ_RELEASES: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (status_read && status_set == 8'h00) |=> (alert_n_oe_n == 1'b1 && status == 8'h00))
        else $error("status read did not release the alert");

    AST_STATUS_STICKY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!status_read && status != 8'h00) |=> ((status & $past(status)) == $past(status)))
        else $error("status bit lost without a read");

    AST_STATUS_NEEDS_EVENT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        1'b1 |=> ((status & ~$past(status) & ~$past(status_set)) == 8'h00))
        else $error("status bit set without a channel event");

    AST_BLOCK_NEEDS_ORING: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!oring_enable[0]) |=> !block_gate_drive[0])
        else $error("block gate driven with oring disabled");

    AST_BLOCK_FOLLOWS_PASS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ((block_gate_drive & ~pass_gate_drive) == 2'h0))
        else $error("block gate on while pass gate off");

    AST_DISABLE_BOTH_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!payload_enable[1]) |=> (!pass_gate_drive[1] && !block_gate_drive[1]))
        else $error("payload disable left a gate on");

    AST_MGMT_ENABLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!mgmt_channel_enable[0] && !mgmt_channel_enable_open[0]) |=> !mgmt_gate_drive[0])
        else $error("management channel on with enable low");

    AST_MGMT_OPEN: assert property (@(posedge ref_clk) disable iff (sys_rst)
        mgmt_channel_enable_open[1] |=> mgmt_gate_drive[1])
        else $error("open enable pin did not enable the channel");

    AST_INTERLOCK: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!interlock_disable && !mgmt_output_voltage_ok[0]) |=> !pass_gate_drive[0])
        else $error("payload turned on before the management rail");

    AST_ADDR_RANGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ##1 (slave_addr - ADDR_BASE) < {2'h0, HSC_ADDR_COUNT})
        else $error("slave address outside the 27 code range");

    AST_ADDR_WEIGHT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (addr_sel_above_low == 3'h7 && addr_sel_above_high == 3'h4) |=> (slave_addr == ADDR_BASE + 7'h16))
        else $error("address pin weights wrong");

    AST_EVENT_DURING_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (status_read && status_set != 8'h00) |=> (alert_n_oe_n == 1'b0 && (status & $past(status_set)) != 8'h00))
        else $error("event lost during status read");

endmodule : hsc_top

//--- inc/hsc_pkg.sv
// shared constants for the hot-swap channel control block
package hsc_pkg;
    // channel counts
    localparam int unsigned HSC_NUM_SLOT = 2;
    localparam int unsigned HSC_NUM_CH = 4;
    localparam int unsigned HSC_STATUS_W = 8;
    // register numbers used by the host protocol
    localparam logic [3:0] HSC_CFG_REG = 4'h6;
    localparam logic [3:0] HSC_STATUS_REG = 4'h7;
    localparam int unsigned HSC_INTERLOCK_BIT = 7;
    // channel index inside the status register, two bits per channel
    localparam int unsigned HSC_CH_MGMT_A = 0;
    localparam int unsigned HSC_CH_PAYLOAD_A = 1;
    localparam int unsigned HSC_CH_MGMT_B = 2;
    localparam int unsigned HSC_CH_PAYLOAD_B = 3;
    localparam int unsigned HSC_FAULT_POS = 0;
    localparam int unsigned HSC_PG_POS = 1;
    // tri-level address pin states and weights
    localparam logic [1:0] HSC_TRIT_GND = 2'h0;
    localparam logic [1:0] HSC_TRIT_OPEN = 2'h1;
    localparam logic [1:0] HSC_TRIT_INTERNAL_SUPPLY_PIN = 2'h2;
    localparam logic [4:0] HSC_ADDR_COUNT = 5'h1B;
    localparam logic [4:0] HSC_WEIGHT_1 = 5'h03;
    localparam logic [4:0] HSC_WEIGHT_2 = 5'h09;
    // reset values
    localparam logic [7:0] HSC_STATUS_RST = 8'h00;
    localparam logic [1:0] HSC_GATE_RST = 2'h0;
    localparam logic [6:0] HSC_ADDR_BASE_DFLT = 7'h30;
endpackage : hsc_pkg

//--- testbench/hsc_host_model.sv
// host-side model that turns read requests into status register read pulses
`timescale 1ns/1ps
module hsc_host_model #(
    parameter int MIN_GAP = 3
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic rd_req,
    output logic status_read
);
    logic [7:0] gap;
    ////////////////////////////////////////////////////////////////////////
    // a real serial read takes many bus clocks, so reads keep a minimum spacing
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_read <= 1'b0;
            gap <= 8'h00;
        end else begin
            status_read <= rd_req && (gap == 8'h00);
            if (rd_req && (gap == 8'h00)) begin
                gap <= 8'(MIN_GAP);
            end else if (gap != 8'h00) begin
                gap <= gap - 8'h01;
            end
        end
    end
endmodule : hsc_host_model

//--- testbench/hsc_top_bench.sv
// self-checking bench for the hot-swap channel control block
`timescale 1ns/1ps
module hsc_top_bench;
    localparam logic [6:0] BASE = 7'h10;
    typedef struct packed {
        logic [1:0] pe, oe; logic il; logic [1:0] ok, en, op, xp, xb, xm;
    } hsc_row_s;
    logic ref_clk = 1'b0, sys_rst = 1'b1, interlock_disable = 1'b0, rd_req = 1'b0, status_read;
    logic [1:0] payload_enable = 2'h0, oring_enable = 2'h0, mgmt_channel_enable = 2'h0;
    logic [1:0] mgmt_channel_enable_open = 2'h0, mgmt_output_voltage_ok = 2'h0;
    logic [3:0] channel_fault = 4'h0, power_good = 4'hF;
    logic [2:0] addr_sel_above_low = 3'h0, addr_sel_above_high = 3'h0;
    logic [1:0] pass_gate_drive, block_gate_drive, mgmt_gate_drive;
    logic [7:0] status;
    logic alert_n_out, alert_n_oe_n;
    logic [6:0] slave_addr;
    int err_count = 0, num_checks = 0, dg;
    hsc_row_s rows [7];
    ////////////////////////////////////////////////////////////////////////
    hsc_top #(.ADDR_BASE(BASE)) i_hsc_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .payload_enable(payload_enable), .oring_enable(oring_enable), .interlock_disable(interlock_disable),
        .mgmt_channel_enable(mgmt_channel_enable), .mgmt_channel_enable_open(mgmt_channel_enable_open),
        .mgmt_output_voltage_ok(mgmt_output_voltage_ok), .channel_fault(channel_fault),
        .power_good(power_good), .status_read(status_read), .addr_sel_above_low(addr_sel_above_low),
        .addr_sel_above_high(addr_sel_above_high), .pass_gate_drive(pass_gate_drive),
        .block_gate_drive(block_gate_drive), .mgmt_gate_drive(mgmt_gate_drive), .status(status),
        .alert_n_out(alert_n_out), .alert_n_oe_n(alert_n_oe_n), .slave_addr(slave_addr));
    hsc_host_model i_hsc_host_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .rd_req(rd_req),
        .status_read(status_read));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    // compare one value and count the outcome
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : step
    // read pulse lands one edge after the request, clears at the edge after that
    task automatic read_clear;
        rd_req = 1'b1;
        step(1);
        rd_req = 1'b0;
        step(1);
        check(status, 8'h00);
        check({6'h0, alert_n_out, alert_n_oe_n}, 8'h01);
        step(3);
    endtask : read_clear
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        $display("MISMATCH at %0t: run did not finish", $time);
        give_verdict();
    end
    // main sequence: reset, gate rows, address sweep, status events, awkward cases
    initial begin
        rows[0] = '{2'h3, 2'h3, 1'b0, 2'h3, 2'h3, 2'h0, 2'h3, 2'h3, 2'h3};
        rows[1] = '{2'h3, 2'h3, 1'b0, 2'h1, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1};
        rows[2] = '{2'h3, 2'h3, 1'b1, 2'h0, 2'h2, 2'h0, 2'h3, 2'h3, 2'h2};
        rows[3] = '{2'h3, 2'h1, 1'b0, 2'h3, 2'h3, 2'h0, 2'h3, 2'h1, 2'h3};
        rows[4] = '{2'h1, 2'h3, 1'b0, 2'h3, 2'h0, 2'h2, 2'h1, 2'h1, 2'h2};
        rows[5] = '{2'h0, 2'h3, 1'b1, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
        rows[6] = '{2'h3, 2'h2, 1'b0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h2, 2'h1};
        step(6);
        check({2'h0, pass_gate_drive, block_gate_drive, mgmt_gate_drive}, 8'h00);
        check(status, hsc_pkg::HSC_STATUS_RST);
        check({1'b0, slave_addr}, {1'b0, BASE});
        check({6'h0, alert_n_out, alert_n_oe_n}, 8'h01);
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            {payload_enable, oring_enable, interlock_disable, mgmt_output_voltage_ok, mgmt_channel_enable,
                mgmt_channel_enable_open} = rows[i][16:6];
            step(1);
            check({2'h0, pass_gate_drive, block_gate_drive, mgmt_gate_drive}, {2'h0, rows[i][5:0]});
        end
        for (int c = 0; c < 27; c++) begin
            for (int k = 0; k < 3; k++) begin
                dg = (k == 0) ? c % 3 : (k == 1) ? (c / 3) % 3 : c / 9;
                addr_sel_above_low[k] = (dg >= 1);
                addr_sel_above_high[k] = (dg == 2);
            end
            step(1);
            check({1'b0, slave_addr}, {1'b0, BASE + 7'(c)});
        end
        for (int ch = 0; ch < 4; ch++) begin
            channel_fault[ch] = 1'b1;
            step(1);
            check(status, 8'h01 << (2 * ch + hsc_pkg::HSC_FAULT_POS));
            check({6'h0, alert_n_out, alert_n_oe_n}, 8'h00);
            channel_fault[ch] = 1'b0;
            read_clear();
            power_good[ch] = 1'b0;
            step(1);
            check(status, 8'h01 << (2 * ch + hsc_pkg::HSC_PG_POS));
            check({6'h0, alert_n_out, alert_n_oe_n}, 8'h00);
            power_good[ch] = 1'b1;
            read_clear();
        end
        // event seen at the very edge that the read clears: it must survive
        rd_req = 1'b1;
        step(1);
        rd_req = 1'b0;
        channel_fault[0] = 1'b1;
        step(1);
        check(status, 8'h01);
        check({6'h0, alert_n_out, alert_n_oe_n}, 8'h00);
        channel_fault[0] = 1'b0;
        step(3);
        read_clear();
        // second reset in mid-run with gates on and an event pending
        {payload_enable, oring_enable, mgmt_output_voltage_ok, mgmt_channel_enable} = 8'hFF;
        channel_fault[3] = 1'b1;
        step(1);
        sys_rst = 1'b1;
        step(2);
        check({2'h0, pass_gate_drive, block_gate_drive, mgmt_gate_drive}, 8'h00);
        check(status, hsc_pkg::HSC_STATUS_RST);
        check({6'h0, alert_n_out, alert_n_oe_n}, 8'h01);
        // release with the fault still high: history restarts low, so it counts as a new event
        sys_rst = 1'b0;
        step(1);
        check({2'h0, pass_gate_drive, block_gate_drive, mgmt_gate_drive}, 8'h3F);
        check(status, 8'h01 << (2 * 3 + hsc_pkg::HSC_FAULT_POS));
        check({6'h0, alert_n_out, alert_n_oe_n}, 8'h00);
        step(1);
        check(status, 8'h01 << (2 * 3 + hsc_pkg::HSC_FAULT_POS));
        give_verdict();
    end
endmodule : hsc_top_bench
